// ==== rtl/fsw_map.svh ====
`ifndef FSW_MAP_SVH
`define FSW_MAP_SVH

// Register indices; byte address is four times the index
`define FSW_IDX_STAT_LO     8'h04
`define FSW_IDX_STAT_HI     8'h05
`define FSW_IDX_CMD         8'h08
`define FSW_IDX_INT_STAT    8'h09
`define FSW_IDX_INT_MASK    8'h0a

// Command register fields
`define FSW_CMD_START_BIT   0
`define FSW_CMD_OFFL_BIT    1

// Status word fields
`define FSW_ST_PASSIVE_BIT  0
`define FSW_ST_LINK_BIT     1
`define FSW_ST_DIAG_BIT     2
`define FSW_ST_VIOL_BIT     3
`define FSW_ST_SLAVE_LSB    4
`define FSW_ST_WD_LSB       6
`define FSW_ST_BAUD_LSB     8
`define FSW_ST_REL_LSB      12

// Interrupt status and mask fields
`define FSW_INT_OFFL_BIT    0
`define FSW_INT_XCHG_BIT    1
`define FSW_INT_WIDTH       2

// Memory folding
`define FSW_MEM_LIMIT       11'd1536
`define FSW_MEM_FOLD        11'd1024

// Slave phase code of the data exchange state
`define FSW_PHASE_EXCHANGE  2'b10

// Reset values
`define FSW_CMD_RESET       2'h0
`define FSW_INT_MASK_RESET  2'h0
`define FSW_RELEASE_DEFAULT 4'h0

`endif

// ==== rtl/fsw_pkg.sv ====
`default_nettype none

package fsw_pkg;

	typedef enum logic [2:0] {
		FSW_OFFLINE  = 3'b001,
		FSW_PASSIVE  = 3'b010,
		FSW_DRAIN    = 3'b100
	} fsw_mode_type;

	typedef logic [15:0] fsw_word_type;

endpackage : fsw_pkg

`default_nettype wire

// ==== rtl/fsw_evt.sv ====
`include "fsw_map.svh"

`default_nettype none

module fsw_evt
	import fsw_pkg::*;
(
	// Clock and reset
	input  wire logic                      core_clk,
	input  wire logic                      rst,
	input  wire logic                      ce,
	// Event sources
	input  wire logic [`FSW_INT_WIDTH-1:0] evt_set,
	// Software access
	input  wire logic                      stat_wr,
	input  wire logic                      mask_wr,
	input  wire logic [`FSW_INT_WIDTH-1:0] wr_data,
	output logic      [`FSW_INT_WIDTH-1:0] stat_q,
	output logic      [`FSW_INT_WIDTH-1:0] mask_q,
	// Interrupt
	output logic                           irq
);

	logic [`FSW_INT_WIDTH-1:0] stat_d;

	// Writing one clears; a new event in the same cycle wins
	always_comb begin
		stat_d = stat_q;
		if (stat_wr) begin
			stat_d = stat_d & ~wr_data;
		end
		stat_d = stat_d | evt_set;
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			stat_q <= '0;
		end else if (ce) begin
			stat_q <= stat_d;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			mask_q <= `FSW_INT_MASK_RESET;
		end else if (ce && mask_wr) begin
			mask_q <= wr_data;
		end
	end

	assign irq = |(stat_q & mask_q);

endmodule : fsw_evt

`default_nettype wire

// ==== rtl/fsw_status.sv ====
// Operation
// - Status word is a read-only live view of state, but the high byte reads the copy frozen at the last low byte read; writes ignored.
// - Bit 0 is 1 in passive idle, 0 when offline.
// - Bit 1 is 1 while a link-layer indication is buffered.
// - Bit 2 is 1 until the master fetches the diagnostics buffer.
// - Bit 3 sets on a memory access above 1536 bytes, holds until the next start.
// - Start command leaves offline, starts timers, clears offline request.
// - Offline request finishes current request, goes offline, self-clears.
// - Reaching offline after a request raises the offline-reached event.
// - Entering or leaving exchange state raises an event.
`include "fsw_map.svh"

`default_nettype none

module fsw_status
	import fsw_pkg::*;
#(
	parameter logic [3:0] RELEASE = `FSW_RELEASE_DEFAULT
)
(
	// Clock, reset and enable
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        ce,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Protocol engine state
	input  wire logic        pending_link_indication,
	input  wire logic        diag_unfetched,
	input  wire logic [1:0]  slave_phase,
	input  wire logic [1:0]  watchdog_phase,
	input  wire logic [3:0]  baud_code,
	input  wire logic        request_busy,
	// Memory access path
	input  wire logic        mem_req,
	input  wire logic [10:0] mem_addr,
	output logic             ram_req,
	output logic      [10:0] ram_addr,
	// Control outputs
	output logic             timers_start,
	output logic             online,
	// Interrupt
	output logic             irq
);

	////////////////////////////////////////////////////////////////////////
	// Bus decode

	function automatic logic hit(input logic [7:0] adr,
	                             input logic [7:0] idx);
		hit = (adr[7:2] == idx[5:0]) && (adr[1:0] == 2'b00);
	endfunction : hit

	logic                      req;
	logic                      wr;
	logic                      rd;
	logic                      ack_q;
	logic [1:0]                cmd_q;
	logic                      viol_q;
	logic [7:0]                snap_hi_q;
	logic [1:0]                phase_q;
	fsw_mode_type              mode_q;
	fsw_mode_type              mode_d;
	fsw_word_type              status_word;
	logic [`FSW_INT_WIDTH-1:0] int_stat;
	logic [`FSW_INT_WIDTH-1:0] int_mask;
	logic [`FSW_INT_WIDTH-1:0] evt_set;
	logic                      start_wr;
	logic                      offl_wr;
	logic                      viol_now;
	logic                      offl_reached;
	logic                      in_xchg;
	logic                      was_xchg;

	assign req = wb_cyc_i && wb_stb_i && !ack_q;
	assign wr  = req && wb_we_i && wb_sel_i[0];
	assign rd  = req && !wb_we_i;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			ack_q <= 1'b0;
		end else if (ce) begin
			ack_q <= req;
		end
	end

	assign wb_ack_o = ack_q;

	////////////////////////////////////////////////////////////////////////
	// Live status word

	always_comb begin
		status_word = '0;
		status_word[`FSW_ST_PASSIVE_BIT] = (mode_q != FSW_OFFLINE);
		status_word[`FSW_ST_LINK_BIT] = pending_link_indication;
		status_word[`FSW_ST_DIAG_BIT] = diag_unfetched;
		status_word[`FSW_ST_VIOL_BIT] = viol_q;
		status_word[`FSW_ST_SLAVE_LSB +: 2] = slave_phase;
		status_word[`FSW_ST_WD_LSB +: 2] = watchdog_phase;
		status_word[`FSW_ST_BAUD_LSB +: 4] = baud_code;
		status_word[`FSW_ST_REL_LSB +: 4] = RELEASE;
	end

	// Low byte read freezes the high byte for the following read
	always_ff @(posedge core_clk) begin
		if (rst) begin
			snap_hi_q <= 8'h00;
		end else if (ce && rd && hit(wb_adr_i, `FSW_IDX_STAT_LO)) begin
			snap_hi_q <= status_word[15:8];
		end
	end

	// Read data; status has no write path at all
	always_ff @(posedge core_clk) begin
		if (rst) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (ce && rd) begin
			wb_dat_o <= 32'h0000_0000;
			if (hit(wb_adr_i, `FSW_IDX_STAT_LO)) begin
				wb_dat_o[7:0] <= status_word[7:0];
			end else if (hit(wb_adr_i, `FSW_IDX_STAT_HI)) begin
				wb_dat_o[7:0] <= snap_hi_q;
			end else if (hit(wb_adr_i, `FSW_IDX_CMD)) begin
				wb_dat_o[1:0] <= cmd_q;
			end else if (hit(wb_adr_i, `FSW_IDX_INT_STAT)) begin
				wb_dat_o[`FSW_INT_WIDTH-1:0] <= int_stat;
			end else if (hit(wb_adr_i, `FSW_IDX_INT_MASK)) begin
				wb_dat_o[`FSW_INT_WIDTH-1:0] <= int_mask;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Command register

	assign start_wr = wr && hit(wb_adr_i, `FSW_IDX_CMD)
	                  && wb_dat_i[`FSW_CMD_START_BIT];
	assign offl_wr  = wr && hit(wb_adr_i, `FSW_IDX_CMD)
	                  && wb_dat_i[`FSW_CMD_OFFL_BIT];

	// Start self-clears at once; offline request clears when offline
	always_ff @(posedge core_clk) begin
		if (rst) begin
			cmd_q <= `FSW_CMD_RESET;
		end else if (ce) begin
			cmd_q[`FSW_CMD_START_BIT] <= 1'b0;
			if (start_wr) begin
				cmd_q[`FSW_CMD_OFFL_BIT] <= 1'b0;
			end else if (offl_wr) begin
				cmd_q[`FSW_CMD_OFFL_BIT] <= 1'b1;
			end else if (offl_reached) begin
				cmd_q[`FSW_CMD_OFFL_BIT] <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Memory address folding

	assign viol_now = mem_req && (mem_addr > `FSW_MEM_LIMIT);

	always_ff @(posedge core_clk) begin
		if (rst) begin
			ram_req  <= 1'b0;
			ram_addr <= 11'h000;
		end else if (ce) begin
			ram_req <= mem_req;
			if (viol_now) begin
				ram_addr <= mem_addr - `FSW_MEM_FOLD;
			end else begin
				ram_addr <= mem_addr;
			end
		end
	end

	// Violation stays flagged until the next start
	always_ff @(posedge core_clk) begin
		if (rst) begin
			viol_q <= 1'b0;
		end else if (ce) begin
			if (viol_now) begin
				viol_q <= 1'b1;
			end else if (start_wr) begin
				viol_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Offline and passive idle sequencing

	always_comb begin
		mode_d = mode_q;
		case (mode_q)
			FSW_OFFLINE: begin
				if (start_wr) begin
					mode_d = FSW_PASSIVE;
				end
			end
			FSW_PASSIVE: begin
				if (offl_wr || cmd_q[`FSW_CMD_OFFL_BIT] || viol_now) begin
					mode_d = FSW_DRAIN;
				end
			end
			FSW_DRAIN: begin
				if (!request_busy) begin
					mode_d = FSW_OFFLINE;
				end
			end
			default: begin
				mode_d = FSW_OFFLINE;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			mode_q <= FSW_OFFLINE;
		end else if (ce) begin
			mode_q <= mode_d;
		end
	end

	assign offl_reached = (mode_q == FSW_DRAIN) && !request_busy;
	assign online       = (mode_q != FSW_OFFLINE);

	always_ff @(posedge core_clk) begin
		if (rst) begin
			timers_start <= 1'b0;
		end else if (ce) begin
			timers_start <= start_wr && (mode_q == FSW_OFFLINE);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Events

	// Track the input through reset so no false event follows it
	always_ff @(posedge core_clk) begin
		if (rst) begin
			phase_q <= slave_phase;
		end else if (ce) begin
			phase_q <= slave_phase;
		end
	end

	assign in_xchg  = (slave_phase == `FSW_PHASE_EXCHANGE);
	assign was_xchg = (phase_q == `FSW_PHASE_EXCHANGE);

	always_comb begin
		evt_set = '0;
		evt_set[`FSW_INT_OFFL_BIT] = offl_reached;
		evt_set[`FSW_INT_XCHG_BIT] = in_xchg != was_xchg;
	end

	fsw_evt u_evt (
		.core_clk (core_clk),
		.rst      (rst),
		.ce       (ce),
		.evt_set  (evt_set),
		.stat_wr  (wr && hit(wb_adr_i, `FSW_IDX_INT_STAT)),
		.mask_wr  (wr && hit(wb_adr_i, `FSW_IDX_INT_MASK)),
		.wr_data  (wb_dat_i[`FSW_INT_WIDTH-1:0]),
		.stat_q   (int_stat),
		.mask_q   (int_mask),
		.irq      (irq)
	);

endmodule : fsw_status

`default_nettype wire

// ==== test/fsw_status_chk.sv ====
`default_nettype none
module fsw_status_chk (
	// Clock, reset, bus
	input wire logic        core_clk,
	input wire logic        rst,
	input wire logic        ce,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_ack_o,
	// Engine and memory
	input wire logic        request_busy,
	input wire logic        mem_req,
	input wire logic [10:0] mem_addr,
	input wire logic        ram_req,
	input wire logic [10:0] ram_addr,
	input wire logic        timers_start,
	input wire logic        online
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence s_take; ce && wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
	sequence s_far; ce && mem_req && mem_addr > 11'd1536; endsequence
	sequence s_near; ce && mem_req && mem_addr <= 11'd1536; endsequence
	property p_ack; s_take |=> wb_ack_o; endproperty
	property p_ackp; wb_ack_o && ce |=> !wb_ack_o; endproperty
	property p_fold; s_far |=> ram_addr == $past(mem_addr) - 11'd1024;
	endproperty
	property p_near; s_near |=> ram_addr == $past(mem_addr); endproperty
	property p_ram; ce |=> ram_req == $past(mem_req); endproperty
	property p_tsp; timers_start && ce |=> !timers_start; endproperty
	property p_tson; timers_start |-> ##[0:1] online; endproperty
	property p_hold; ce && online && request_busy |=> online; endproperty
	a_ack: assert property (p_ack)
		else $error("request not acknowledged");
	a_ackp: assert property (p_ackp)
		else $error("ack longer than one cycle");
	a_fold: assert property (p_fold)
		else $error("far address not folded");
	a_near: assert property (p_near)
		else $error("near address altered");
	a_ram: assert property (p_ram)
		else $error("memory request not passed");
	a_tsp: assert property (p_tsp)
		else $error("timer start not a pulse");
	a_tson: assert property (p_tson)
		else $error("timer start while offline");
	a_hold: assert property (p_hold)
		else $error("left before request finished");
endmodule : fsw_status_chk
bind fsw_status fsw_status_chk u_chk (.core_clk(core_clk), .rst(rst),
	.ce(ce), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
	.request_busy(request_busy), .mem_req(mem_req), .mem_addr(mem_addr),
	.ram_req(ram_req), .ram_addr(ram_addr), .timers_start(timers_start),
	.online(online));
`default_nettype wire

// ==== test/fsw_eng_model.sv ====
`default_nettype none
module fsw_eng_model #(
	parameter int SLOW = 12
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Start of a long request
	input wire logic go,
	// Engine state
	output logic     request_busy
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt_q;
	// Busy a while after go, so a drain must wait
	always_ff @(posedge core_clk) begin
		if (rst) cnt_q <= 0;
		else if (go) cnt_q <= SLOW;
		else if (cnt_q > 0) cnt_q <= cnt_q - 1;
	end
	assign request_busy = cnt_q > 0;
endmodule : fsw_eng_model
`default_nettype wire

// ==== test/fsw_status_tb.sv ====
`default_nettype none
module fsw_status_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [3:0] REL = 4'h5; // Arbitrary release number
	logic        core_clk = 0, rst = 1, ce = 1, cyc = 0, stb = 0, we = 0;
	logic        go = 0, link = 0, diag = 0, mreq = 0;
	logic        ack, busy, rreq, ts, online, irq;
	logic [1:0]  sp = 0, wd = 0;
	logic [3:0]  baud = 0;
	logic [7:0]  adr = 0;
	logic [10:0] maddr = 0, raddr;
	logic [31:0] wdat = 0, dat_o, q, seed = 33;
	logic [15:0] snap;
	int          error_cnt = 0, cmp_count = 0, on = 0, viol = 0, n;
	always #5 core_clk = ~core_clk;
	fsw_status #(.RELEASE(REL)) DUT (.core_clk(core_clk), .rst(rst),
		.ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o),
		.wb_ack_o(ack), .pending_link_indication(link),
		.diag_unfetched(diag), .slave_phase(sp), .watchdog_phase(wd),
		.baud_code(baud), .request_busy(busy), .mem_req(mreq),
		.mem_addr(maddr), .ram_req(rreq), .ram_addr(raddr),
		.timers_start(ts), .online(online), .irq(irq));
	fsw_eng_model u_eng (.core_clk(core_clk), .rst(rst), .go(go),
		.request_busy(busy));
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	function logic [15:0] word();
		return {REL, baud, wd, sp, viol[0], diag, link, on[0]};
	endfunction : word
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge core_clk);
		end while (ack !== 1'b1);
		q = dat_o;
		cyc <= 0;
		stb <= 0;
		we <= 0;
	endtask : wb
	task test_done();
		$display("compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : test_done
	initial begin
		#300000;
		error_cnt++;
		test_done();
	end
	initial begin
		repeat (20) @(posedge core_clk);
		rst <= 0;
		wb(0, 8'h20, 0); chk(q, 0);
		wb(0, 8'h3c, 0); chk(q, 0);
		wb(1, 8'h10, 32'hff);
		wb(0, 8'h10, 0); chk(q, 32'(word() & 16'hff));
		wb(1, 8'h20, 1);
		chk(32'(ts), 1);
		on = 1;
		$display("reset and start done");
		repeat (8) begin
			{link, diag, wd, baud} <= 8'(rnd());
			sp <= 2'(rnd() % 3);
			wb(0, 8'h10, 0);
			snap = word();
			chk(q, 32'(snap[7:0]));
			{link, diag, baud} <= 6'(rnd());
			wb(0, 8'h14, 0); chk(q, 32'(snap[15:8]));
		end
		$display("status word done");
		sp <= 0;
		wb(1, 8'h28, 3);
		wb(1, 8'h24, 3);
		chk(32'(irq), 0);
		sp <= 2;
		wb(0, 8'h24, 0); chk(q, 2);
		chk(32'(irq), 1);
		wb(1, 8'h24, 2);
		chk(32'(irq), 0);
		$display("exchange event done");
		// Phase dips and returns while frozen: no event may follow
		ce <= 0;
		sp <= 0;
		repeat (3) @(posedge core_clk);
		sp <= 2;
		@(posedge core_clk);
		ce <= 1;
		wb(0, 8'h24, 0); chk(q, 0);
		$display("clock enable done");
		go <= 1;
		wb(1, 8'h20, 2);
		go <= 0;
		chk(32'(online), 1);
		n = 0;
		while (busy && n < 50) begin
			@(posedge core_clk);
			n++;
		end
		on = 0;
		wb(0, 8'h10, 0); chk(q, 32'(word() & 16'hff));
		wb(0, 8'h20, 0); chk(q, 0);
		wb(0, 8'h24, 0); chk(q, 1);
		wb(1, 8'h24, 1);
		$display("offline request done");
		wb(1, 8'h20, 1);
		on = 1;
		mreq <= 1;
		maddr <= 11'd1536;
		@(posedge core_clk);
		maddr <= 11'd1600;
		@(negedge core_clk);
		chk(32'(rreq), 1);
		chk(32'(raddr), 1536);
		@(posedge core_clk);
		mreq <= 0;
		@(negedge core_clk);
		chk(32'(raddr), 576);
		viol = 1;
		on = 0;
		repeat (4) @(posedge core_clk);
		wb(0, 8'h10, 0); chk(q, 32'(word() & 16'hff));
		wb(0, 8'h24, 0); chk(q, 1);
		wb(1, 8'h20, 1);
		viol = 0;
		on = 1;
		wb(0, 8'h10, 0); chk(q, 32'(word() & 16'hff));
		$display("violation done");
		rst <= 1;
		repeat (2) @(posedge core_clk);
		rst <= 0;
		on = 0;
		wb(0, 8'h24, 0); chk(q, 0);
		wb(0, 8'h14, 0); chk(q, 0);
		wb(0, 8'h10, 0); chk(q, 32'(word() & 16'hff));
		$display("second reset done");
		test_done();
	end
endmodule : fsw_status_tb
`default_nettype wire
